/* smbus_cfg_pkg.sv */
// Package of constants for the serial configuration register bank.
// Assumes a host that follows the two-wire write and read framing.
package smbus_cfg_pkg;
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h50;
    localparam int ADDR_SEL_LSB = 1;
    localparam logic [7:0] OFS_SOFT_RESET = 8'h00;
    localparam logic [7:0] OFS_CH_POWER_DOWN_PIN = 8'h01;
    localparam logic [7:0] OFS_POWER_DOWN_PIN_OVR = 8'h02;
    localparam logic [7:0] OFS_PIN_OVR = 8'h08;
    localparam logic [7:0] OFS_CH0_IDLE_RATE = 8'h0E;
    localparam logic [7:0] OFS_IDLE_ROUTE = 8'h47;
    localparam logic [7:0] OFS_RATE_ROUTE = 8'h4C;
    localparam logic [7:0] OFS_GPIO_MODE = 8'h4E;
    localparam logic [7:0] RST_VAL = 8'h00;
    localparam int SOFT_RESET_BIT = 0;
    localparam int POWER_DOWN_PIN_OVR_BIT = 0;
    localparam int OVR_IDLE_BIT = 4;
    localparam int OVR_RATE_BIT = 2;
    localparam int IDLE_AUTO_BIT = 5;
    localparam int IDLE_SEL_BIT = 4;
    localparam int RATE_AUTO_BIT = 1;
    localparam int RATE_SEL_BIT = 0;
    localparam int GPIO_MODE_BIT = 0;
    localparam int IDLE_ROUTE_LSB = 4;
    localparam int RATE_ROUTE_LSB = 6;
    localparam int T_BUF_NS = 4700;
    localparam int T_HIGH_MAX_NS = 50000;
    localparam int CLK_NS = 20;
    localparam int BUF_CYC = (T_BUF_NS + CLK_NS - 1) / CLK_NS;
    localparam int HIGH_MAX_CYC = T_HIGH_MAX_NS / CLK_NS;
endpackage : smbus_cfg_pkg

/* smbus_link.sv */
// Serial link end: start/stop detection, byte shifting and acknowledge.
// Runs on the serial clock pin; sda is sampled on its edges.
`timescale 1ns/1ps
`default_nettype none
module smbus_link (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [3:0] addr_sel_i,
    input wire logic [7:0] rd_data_i,
    output logic sda_oe_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] wr_data_o,
    output logic wr_toggle_o
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_DEV = 3'b001,
        S_REG = 3'b010,
        S_DATA = 3'b011,
        S_READ = 3'b100,
        S_RACK = 3'b101
    } link_t;
    link_t state = S_IDLE;
    link_t next_state;
    logic [7:0] shift = 8'h00;
    logic [3:0] cnt = 4'h0;
    logic start_t = 1'b0;
    logic start_seen = 1'b0;
    logic stop_t = 1'b0;
    logic stop_seen = 1'b0;
    logic oe = 1'b0;
    logic more = 1'b0;
    logic tgl = 1'b0;
    logic [7:0] rd_shift = 8'h00;
    logic [6:0] my_addr;
    logic [2:0] bit_idx;
    wire [7:0] shifted = {shift[6:0], sda_i};
    wire addr_hit = shift[7:1] == my_addr;
    wire start_new = start_t != start_seen;
    wire dev_done = cnt == 4'h8 && state == S_DEV;
    wire reg_done = cnt == 4'h8 && state == S_REG;
    wire data_done = cnt == 4'h8 && state == S_DATA;
    wire read_bit = state == S_READ && cnt != 4'h8;
    // The strap pins fill the low four bits of the seven-bit address.
    assign my_addr = smbus_cfg_pkg::SLAVE_ADDR_BASE
        | {3'b000, addr_sel_i};
    assign bit_idx = 3'h7 - cnt[2:0];
    assign wr_toggle_o = tgl;
    always_ff @(negedge sda_i) begin
        if (scl_i) begin
            start_t <= ~start_t;
        end
    end
    always_ff @(posedge sda_i) begin
        if (scl_i) begin
            stop_t <= ~stop_t;
        end
    end
    always_ff @(posedge scl_i) begin
        start_seen <= start_t;
        stop_seen <= stop_t;
        if (start_new) begin
            state <= S_DEV;
            cnt <= 4'h1;
            shift <= {7'h00, sda_i};
        end else if (stop_t != stop_seen) begin
            state <= S_IDLE;
            cnt <= 4'h0;
        end else if (state != S_IDLE) begin
            if (cnt == 4'h8) begin
                cnt <= 4'h0;
                state <= next_state;
            end else begin
                cnt <= cnt + 4'h1;
                shift <= shifted;
            end
        end
    end
    always_comb begin
        next_state = state;
        case (state)
            S_DEV: begin
                if (!addr_hit) begin
                    next_state = S_IDLE;
                end else if (shift[0]) begin
                    next_state = S_READ;
                end else begin
                    next_state = S_REG;
                end
            end
            S_REG: next_state = S_DATA;
            S_READ: next_state = sda_i ? S_IDLE : S_READ;
            default: next_state = state;
        endcase
    end
    // The data line only changes after a falling clock edge.
    always_ff @(negedge scl_i) begin
        if (state == S_IDLE || start_new) begin
            oe <= 1'b0;
        end else if (dev_done) begin
            oe <= addr_hit;
            rd_shift <= rd_data_i;
        end else if (reg_done) begin
            oe <= 1'b1;
            reg_addr_o <= shift;
            more <= 1'b0;
        end else if (data_done) begin
            oe <= 1'b1;
            wr_data_o <= shift;
            tgl <= ~tgl;
            more <= 1'b1;
            if (more) begin
                reg_addr_o <= reg_addr_o + 8'h01;
            end
        end else if (read_bit) begin
            oe <= !rd_shift[bit_idx];
        end else begin
            oe <= 1'b0;
        end
    end
    assign sda_oe_o = oe;
endmodule : smbus_link
`default_nettype wire

/* smbus_config_register_bank.sv */
// Configuration register bank behind the two-wire serial slave.
// Assumes pins arrive asynchronously; scl is the link's own clock.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Serial access and registers active only while mode select is high.
// - Slave address 1010000 with address-select pins replacing bits 3:0.
// - Floating address-select pins read zero, default write byte A0.
// - Falling sda with scl high starts, rising sda with scl high stops.
// - Bus idle after bus-free time or maximum clock-high time.
// - Write is address, register, data, each acknowledged low.
// - Read uses repeated start, returns register byte, host nacks.
// - Writing one to bit 0 of offset 0 restores all defaults.
// - Power-down register holds one disable bit per channel.
// - Override bit set ignores power-down pin, cleared lets pin rule.
// - Override bits block idle pins (bit 4) and rate pin (bit 2).
// - Idle auto bit selects automatic detect, else manual idle select.
// - Manual idle select 0 keeps output on, 1 forces electrical idle.
// - Rate auto bit enables detection, else rate select bit chooses.
// - Bit 0 of 0x4E turns address pins into four status outputs.
// - Status outputs are OR of blocks enabled in 0x47 and 0x4C.
// - Idle routing pairs channels 0|2,1|3,4|6,5|7; high means idle.
// - Rate routing uses same pairs; high means high rate.
// - Rate status high for 6 Gbps, low for 3 Gbps.
// - Idle status high when no signal, low with data.
// - Registers return to defaults at power-up and mode select low.
// - Power-down pin in serial mode leaves registers unchanged.
// - Manual rate select 0 is low range, 1 is high range.
module smbus_config_register_bank (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic mode_select_i,
    input wire logic [3:0] addr_sel_i,
    input wire logic power_down_pin_i,
    input wire logic idle_pin_i,
    input wire logic idle_pin_auto_i,
    input wire logic rate_pin_i,
    input wire logic rate_pin_auto_i,
    input wire logic [7:0] ch_idle_det_i,
    input wire logic [7:0] ch_rate_det_i,
    output logic [7:0] ch_power_down_o,
    output logic [7:0] ch_force_idle_o,
    output logic [7:0] ch_auto_idle_o,
    output logic [7:0] ch_auto_rate_o,
    output logic [7:0] ch_high_rate_o,
    output logic [3:0] status_o,
    output logic [3:0] status_oe_o,
    output logic bus_idle_o
);
    logic [7:0] soft_reset_control;
    logic [7:0] channel_power_down;
    logic [7:0] power_down_pin_override;
    logic [7:0] pin_control_override;
    logic [7:0] ch0_idle_rate_select;
    logic [7:0] idle_route;
    logic [7:0] rate_route;
    logic [7:0] gpio_mode;
    logic [7:0] link_addr;
    logic [7:0] link_data;
    logic link_tgl;
    logic [1:0] mode_sync;
    logic [1:0] pd_sync;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [2:0] tgl_sync;
    logic [7:0] idle_sync1;
    logic [7:0] idle_sync2;
    logic [7:0] rate_sync1;
    logic [7:0] rate_sync2;
    logic [3:0] addr_sync1;
    logic [3:0] addr_sync2;
    logic [3:0] addr_latch;
    logic [15:0] idle_cnt;
    logic stop_flag;
    logic [1:0] sda_hist;
    logic [7:0] rd_data;
    logic link_oe;
    logic [3:0] pin_sync1;
    logic [3:0] pin_sync2;
    wire smb_on = mode_sync[1];
    wire wr_pulse = tgl_sync[2] ^ tgl_sync[1];
    wire soft_rst = soft_reset_control[smbus_cfg_pkg::SOFT_RESET_BIT];
    wire regs_clear = !rstn_i || !smb_on || soft_rst;
    wire bus_high = scl_sync[1] && sda_sync[1];
    wire stop_now = scl_sync[1] && sda_hist[0] && !sda_hist[1];
    wire route_on = gpio_mode[smbus_cfg_pkg::GPIO_MODE_BIT];
    wire pin_pd_ok = !power_down_pin_override[smbus_cfg_pkg::POWER_DOWN_PIN_OVR_BIT];
    wire idle_blk = pin_control_override[smbus_cfg_pkg::OVR_IDLE_BIT];
    wire rate_blk = pin_control_override[smbus_cfg_pkg::OVR_RATE_BIT];
    wire [1:0] idle_en = idle_route[smbus_cfg_pkg::IDLE_ROUTE_LSB +: 2];
    wire [1:0] rate_en = rate_route[smbus_cfg_pkg::RATE_ROUTE_LSB +: 2];
    wire idle_pin_s = pin_sync2[0];
    wire idle_auto_s = pin_sync2[1];
    wire rate_pin_s = pin_sync2[2];
    wire rate_auto_s = pin_sync2[3];
    logic [7:0] ch_sel [0:7];
    smbus_link u_link (
        .scl_i(scl_i),
        .sda_i(sda_i),
        .addr_sel_i(route_on ? 4'h0 : addr_latch),
        .rd_data_i(rd_data),
        .sda_oe_o(link_oe),
        .reg_addr_o(link_addr),
        .wr_data_o(link_data),
        .wr_toggle_o(link_tgl)
    );
    assign sda_o = 1'b0;
    assign sda_oe_o = link_oe && smb_on;
    always_ff @(posedge core_clk_i) begin
        mode_sync <= {mode_sync[0], mode_select_i};
        pd_sync <= {pd_sync[0], power_down_pin_i};
        scl_sync <= {scl_sync[0], scl_i};
        sda_sync <= {sda_sync[0], sda_i};
        tgl_sync <= {tgl_sync[1:0], link_tgl};
        idle_sync1 <= ch_idle_det_i;
        idle_sync2 <= idle_sync1;
        rate_sync1 <= ch_rate_det_i;
        rate_sync2 <= rate_sync1;
        addr_sync1 <= addr_sel_i;
        addr_sync2 <= addr_sync1;
        pin_sync1 <= {rate_pin_auto_i, rate_pin_i,
            idle_pin_auto_i, idle_pin_i};
        pin_sync2 <= pin_sync1;
        sda_hist <= {sda_hist[0], sda_sync[1]};
        if (!rstn_i) begin
            addr_latch <= 4'h0;
        end else if (!route_on) begin
            addr_latch <= addr_sync2;
        end
    end
    // Register writes arrive from the link domain by toggle handshake.
    always_ff @(posedge core_clk_i) begin
        if (regs_clear) begin
            soft_reset_control <= smbus_cfg_pkg::RST_VAL;
            channel_power_down <= smbus_cfg_pkg::RST_VAL;
            power_down_pin_override <= smbus_cfg_pkg::RST_VAL;
            pin_control_override <= smbus_cfg_pkg::RST_VAL;
            ch0_idle_rate_select <= smbus_cfg_pkg::RST_VAL;
            idle_route <= smbus_cfg_pkg::RST_VAL;
            rate_route <= smbus_cfg_pkg::RST_VAL;
            gpio_mode <= smbus_cfg_pkg::RST_VAL;
        end else if (wr_pulse) begin
            case (link_addr)
                smbus_cfg_pkg::OFS_SOFT_RESET: begin
                    soft_reset_control <= link_data;
                end
                smbus_cfg_pkg::OFS_CH_POWER_DOWN_PIN: begin
                    channel_power_down <= link_data;
                end
                smbus_cfg_pkg::OFS_POWER_DOWN_PIN_OVR: begin
                    power_down_pin_override <= link_data;
                end
                smbus_cfg_pkg::OFS_PIN_OVR: begin
                    pin_control_override <= link_data;
                end
                smbus_cfg_pkg::OFS_CH0_IDLE_RATE: begin
                    ch0_idle_rate_select <= link_data;
                end
                smbus_cfg_pkg::OFS_IDLE_ROUTE: begin
                    idle_route <= link_data;
                end
                smbus_cfg_pkg::OFS_RATE_ROUTE: begin
                    rate_route <= link_data;
                end
                smbus_cfg_pkg::OFS_GPIO_MODE: begin
                    gpio_mode <= link_data;
                end
                default: begin
                    gpio_mode <= gpio_mode;
                end
            endcase
        end
    end
    // Read mux is sampled by the link at the falling edge that ends the address byte, before its acknowledge.
    always_comb begin
        case (link_addr)
            smbus_cfg_pkg::OFS_SOFT_RESET: rd_data = soft_reset_control;
            smbus_cfg_pkg::OFS_CH_POWER_DOWN_PIN: rd_data = channel_power_down;
            smbus_cfg_pkg::OFS_POWER_DOWN_PIN_OVR: rd_data = power_down_pin_override;
            smbus_cfg_pkg::OFS_PIN_OVR: rd_data = pin_control_override;
            smbus_cfg_pkg::OFS_CH0_IDLE_RATE: rd_data = ch0_idle_rate_select;
            smbus_cfg_pkg::OFS_IDLE_ROUTE: rd_data = idle_route;
            smbus_cfg_pkg::OFS_RATE_ROUTE: rd_data = rate_route;
            smbus_cfg_pkg::OFS_GPIO_MODE: rd_data = gpio_mode;
            default: rd_data = 8'h00;
        endcase
    end
    // Bus idle timer counts while both lines stay high.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            idle_cnt <= 16'h0000;
            stop_flag <= 1'b0;
            bus_idle_o <= 1'b1;
        end else begin
            if (stop_now) begin
                stop_flag <= 1'b1;
            end else if (!bus_high) begin
                stop_flag <= 1'b0;
            end
            if (!bus_high) begin
                idle_cnt <= 16'h0000;
                bus_idle_o <= 1'b0;
            end else begin
                if (idle_cnt != 16'hFFFF) begin
                    idle_cnt <= idle_cnt + 16'h0001;
                end
                if ((stop_flag && idle_cnt >= 16'(smbus_cfg_pkg::BUF_CYC))
                    || idle_cnt >= 16'(smbus_cfg_pkg::HIGH_MAX_CYC)) begin
                    bus_idle_o <= 1'b1;
                end
            end
        end
    end
    // Channel 0 has its own select register; others share its settings.
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_ch
            assign ch_sel[g] = ch0_idle_rate_select;
            wire pin_idle_rules = smb_on ? !idle_blk : 1'b1;
            wire pin_rate_rules = smb_on ? !rate_blk : 1'b1;
            wire auto_idle = pin_idle_rules ? idle_auto_s
                : ch_sel[g][smbus_cfg_pkg::IDLE_AUTO_BIT];
            wire man_idle = pin_idle_rules ? idle_pin_s
                : ch_sel[g][smbus_cfg_pkg::IDLE_SEL_BIT];
            wire auto_rate = pin_rate_rules ? rate_auto_s
                : ch_sel[g][smbus_cfg_pkg::RATE_AUTO_BIT];
            wire man_rate = pin_rate_rules ? rate_pin_s
                : ch_sel[g][smbus_cfg_pkg::RATE_SEL_BIT];
            always_ff @(posedge core_clk_i) begin
                if (!rstn_i) begin
                    ch_power_down_o[g] <= 1'b0;
                    ch_force_idle_o[g] <= 1'b0;
                    ch_auto_idle_o[g] <= 1'b0;
                    ch_auto_rate_o[g] <= 1'b0;
                    ch_high_rate_o[g] <= 1'b0;
                end else begin
                    ch_power_down_o[g] <= channel_power_down[g]
                        | (pd_sync[1] & (pin_pd_ok | !smb_on));
                    ch_auto_idle_o[g] <= auto_idle;
                    ch_force_idle_o[g] <= !auto_idle && man_idle;
                    ch_auto_rate_o[g] <= auto_rate;
                    ch_high_rate_o[g] <= auto_rate ? rate_sync2[g]
                        : man_rate;
                end
            end
        end
        for (g = 0; g < 4; g++) begin : g_stat
            localparam int LO = (g < 2) ? g : g + 2;
            wire idle_or = (idle_en[0] & idle_sync2[LO])
                | (idle_en[1] & idle_sync2[LO + 2]);
            wire rate_or = (rate_en[0] & rate_sync2[LO])
                | (rate_en[1] & rate_sync2[LO + 2]);
            always_ff @(posedge core_clk_i) begin
                if (!rstn_i) begin
                    status_o[g] <= 1'b0;
                    status_oe_o[g] <= 1'b0;
                end else begin
                    status_o[g] <= idle_or | rate_or;
                    status_oe_o[g] <= route_on && smb_on;
                end
            end
        end
    endgenerate
    a_soft_reset_clears: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) soft_rst |=> soft_reset_control == 8'h00)
        else $error("soft reset did not clear");
    a_mode_low_clears: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) !smb_on |=> channel_power_down == 8'h00)
        else $error("registers kept with mode low");
    a_sda_off_mode: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) !smb_on |-> !sda_oe_o)
        else $error("sda driven outside serial mode");
    a_status_oe_route: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) (route_on && smb_on) |=> status_oe_o == 4'hF)
        else $error("status pins not enabled");
    a_status_oe_off: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) !(route_on && smb_on) |=> status_oe_o == 4'h0)
        else $error("status pins driven while not routed");
    a_power_down_pin_reg: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) channel_power_down == 8'hFF
        |=> ch_power_down_o == 8'hFF)
        else $error("channels not powered down");
    a_power_down_pin_override: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) (smb_on && !pin_pd_ok
        && channel_power_down == 8'h00) |=> ch_power_down_o == 8'h00)
        else $error("power-down pin not ignored");
    a_pin_pd_rules: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) (!smb_on && pd_sync[1])
        |=> ch_power_down_o == 8'hFF)
        else $error("power-down pin not obeyed");
    a_idle_route_or: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) (idle_en == 2'b11 && rate_en == 2'b00)
        |=> status_o[0] == ($past(idle_sync2[0]) | $past(idle_sync2[2])))
        else $error("idle status wrong");
    a_rate_route_or: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) (rate_en == 2'b11 && idle_en == 2'b00)
        |=> status_o[1] == ($past(rate_sync2[1]) | $past(rate_sync2[3])))
        else $error("rate status wrong");
    a_force_idle_man: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) (smb_on && idle_blk
        && ch0_idle_rate_select[5:4] == 2'b01) |=> ch_force_idle_o == 8'hFF)
        else $error("manual idle not forced");
    a_idle_out_on: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) (smb_on && idle_blk
        && ch0_idle_rate_select[5:4] == 2'b00) |=> ch_force_idle_o == 8'h00)
        else $error("output idled with select low");
    a_idle_auto_sel: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) (smb_on && idle_blk && ch0_idle_rate_select[5])
        |=> ch_auto_idle_o == 8'hFF && ch_force_idle_o == 8'h00)
        else $error("automatic idle not selected");
    a_rate_manual_sel: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) (smb_on && rate_blk
        && ch0_idle_rate_select[1:0] == 2'b01) |=> ch_high_rate_o == 8'hFF)
        else $error("manual high rate not chosen");
    a_rate_auto_follow: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) (smb_on && rate_blk && ch0_idle_rate_select[1])
        |=> ch_high_rate_o == $past(rate_sync2))
        else $error("automatic rate not followed");
    a_bus_idle_low: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) !bus_high |=> !bus_idle_o)
        else $error("idle while bus busy");
    a_bus_idle_max: assert property (@(posedge core_clk_i)
        disable iff (!rstn_i) (bus_high
        && idle_cnt >= 16'(smbus_cfg_pkg::HIGH_MAX_CYC)) |=> bus_idle_o)
        else $error("bus not idle after long high time");
endmodule : smbus_config_register_bank
`default_nettype wire

/* smbus_host_model.sv */
// Two-wire host model driving the serial clock and the host side of data.
// Assumes a pull-up on the data wire, so a released line reads high.
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic start_cond(input logic rep);
        if (rep) begin
            #1.5 sda_o = 1'b1;
            #1.5 scl_o = 1'b1;
        end
        #3 sda_o = 1'b0;
        #3 scl_o = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #1.5 sda_o = 1'b0;
        #1.5 scl_o = 1'b1;
        #3 sda_o = 1'b1;
        #3;
    endtask : stop_cond
    // Data changes only while the clock is low.
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #1.5 sda_o = tx[i];
            #1.5 scl_o = 1'b1;
            #1.5 rx[i] = sda_i;
            #1.5 scl_o = 1'b0;
        end
    endtask : xfer
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
        input logic [7:0] val, output logic [2:0] acks);
        logic [8:0] rx;
        start_cond(1'b0);
        xfer({dev, 1'b0, 1'b1}, rx);
        acks[2] = rx[0];
        xfer({ofs, 1'b1}, rx);
        acks[1] = rx[0];
        xfer({val, 1'b1}, rx);
        acks[0] = rx[0];
        stop_cond();
    endtask : write_reg
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
        output logic [7:0] val, output logic [2:0] acks);
        logic [8:0] rx;
        start_cond(1'b0);
        xfer({dev, 1'b0, 1'b1}, rx);
        acks[2] = rx[0];
        xfer({ofs, 1'b1}, rx);
        acks[1] = rx[0];
        start_cond(1'b1);
        xfer({dev, 1'b1, 1'b1}, rx);
        acks[0] = rx[0];
        xfer(9'h1FF, rx);
        val = rx[8:1];
        stop_cond();
    endtask : read_reg
endmodule : smbus_host_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the serial configuration register bank.
// Assumes the host model as the only other driver of the data wire.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic mode_select = 1'b0;
    logic [3:0] addr_sel = 4'h0;
    logic power_down_pin = 1'b0;
    logic idle_pin = 1'b0;
    logic idle_pin_auto = 1'b1;
    logic rate_pin = 1'b0;
    logic rate_pin_auto = 1'b1;
    logic [7:0] idle_det = 8'h00;
    logic [7:0] rate_det = 8'h00;
    logic [6:0] dev_addr = 7'h50;
    logic scl, host_sda, dut_sda, dut_sda_oe, bus_idle;
    logic [7:0] ch_pd, ch_force, ch_aidle, ch_arate, ch_high;
    logic [3:0] status, status_oe;
    wire logic sda = (dut_sda_oe ? dut_sda : 1'b1) & host_sda;
    int mismatches = 0;
    int compares = 0;
    initial forever #10 core_clk = ~core_clk;
    smbus_host_model u_smbus_host_model (.sda_i(sda), .scl_o(scl),
        .sda_o(host_sda));
    smbus_config_register_bank u_smbus_config_register_bank (
        .core_clk_i(core_clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda),
        .sda_o(dut_sda), .sda_oe_o(dut_sda_oe), .mode_select_i(mode_select),
        .addr_sel_i(addr_sel), .power_down_pin_i(power_down_pin),
        .idle_pin_i(idle_pin), .idle_pin_auto_i(idle_pin_auto),
        .rate_pin_i(rate_pin), .rate_pin_auto_i(rate_pin_auto),
        .ch_idle_det_i(idle_det), .ch_rate_det_i(rate_det),
        .ch_power_down_o(ch_pd), .ch_force_idle_o(ch_force),
        .ch_auto_idle_o(ch_aidle), .ch_auto_rate_o(ch_arate),
        .ch_high_rate_o(ch_high), .status_o(status),
        .status_oe_o(status_oe), .bus_idle_o(bus_idle));
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
        logic [2:0] acks;
        u_smbus_host_model.write_reg(dev_addr, ofs, val, acks);
        chk("write acks", 8'h00, {5'h00, acks});
        cyc(8);
    endtask : wr
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        logic [2:0] acks;
        logic [7:0] val;
        u_smbus_host_model.read_reg(dev_addr, ofs, val, acks);
        chk("read acks", 8'h00, {5'h00, acks});
        chk("read data", exp, val);
        cyc(8);
    endtask : rd
    task automatic t_defaults();
        logic [7:0] ofs [5] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h0E};
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        wait_idle();
    endtask : t_defaults
    task automatic wait_idle();
        int n;
        n = 0;
        while (bus_idle !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
        chk("bus idle", 8'h01, {7'h00, bus_idle});
        if (bus_idle !== 1'b1) begin
            wrap_up();
        end
    endtask : wait_idle
    task automatic t_address();
        logic [2:0] acks;
        @(posedge core_clk) addr_sel <= 4'h5;
        cyc(4);
        dev_addr = smbus_cfg_pkg::SLAVE_ADDR_BASE | 7'h05;
        wr(8'h01, 8'hA5);
        chk("busy after stop", 8'h00, {7'h00, bus_idle});
        wait_idle();
        rd(8'h01, 8'hA5);
        u_smbus_host_model.write_reg(7'h50, 8'h01, 8'h00, acks);
        chk("foreign addr ack", 8'h01, {7'h00, acks[2]});
        cyc(8);
        rd(8'h01, 8'hA5);
        @(posedge core_clk) addr_sel <= 4'h0;
        cyc(4);
        dev_addr = smbus_cfg_pkg::SLAVE_ADDR_BASE;
    endtask : t_address
    task automatic t_power();
        wr(8'h01, 8'hFF);
        chk("all channels down", 8'hFF, ch_pd);
        wr(8'h01, 8'h0F);
        chk("side b down", 8'h0F, ch_pd);
        @(posedge core_clk) power_down_pin <= 1'b1;
        cyc(6);
        chk("pin rules", 8'hFF, ch_pd);
        wr(8'h02, 8'h01);
        chk("pin blocked", 8'h0F, ch_pd);
        rd(8'h01, 8'h0F);
        @(posedge core_clk) power_down_pin <= 1'b0;
    endtask : t_power
    task automatic t_idle_rate();
        logic [7:0] codes [4] = '{8'h10, 8'h20, 8'h02, 8'h01};
        logic [7:0] c;
        wr(8'h08, 8'h14);
        foreach (codes[i]) begin
            c = codes[i];
            wr(8'h0E, c);
            chk("force idle", {8{~c[5] & c[4]}}, ch_force);
            chk("auto idle", {8{c[5]}}, ch_aidle);
            chk("auto rate", {8{c[1]}}, ch_arate);
            chk("high rate", {8{~c[1] & c[0]}}, ch_high);
        end
    endtask : t_idle_rate
    task automatic t_status();
        wr(8'h4E, 8'h01);
        wr(8'h47, 8'h32);
        @(posedge core_clk) idle_det <= 8'h04;
        cyc(6);
        chk("status enables", 8'h0F, {4'h0, status_oe});
        chk("idle pair 0|2", 8'h01, {4'h0, status});
        @(posedge core_clk) idle_det <= 8'hA0;
        cyc(6);
        chk("idle pair 5|7", 8'h08, {4'h0, status});
        wr(8'h47, 8'h00);
        wr(8'h4C, 8'hC0);
        @(posedge core_clk) rate_det <= 8'h08;
        cyc(6);
        chk("rate pair 1|3", 8'h02, {4'h0, status});
        wr(8'h47, 8'h32);
        chk("ored blocks", 8'h0A, {4'h0, status});
    endtask : t_status
    task automatic t_soft_reset();
        wr(8'h00, 8'h01);
        rd(8'h01, 8'h00);
        rd(8'h4E, 8'h00);
        chk("status released", 8'h00, {4'h0, status_oe});
        wr(8'h11, 8'h88);
        rd(8'h11, 8'h00);
    endtask : t_soft_reset
    task automatic t_mode();
        logic [2:0] acks;
        wr(8'h08, 8'h14);
        @(posedge core_clk) mode_select <= 1'b0;
        cyc(4);
        u_smbus_host_model.write_reg(dev_addr, 8'h02, 8'h01, acks);
        chk("mode low ack", 8'h01, {7'h00, acks[2]});
        @(posedge core_clk) mode_select <= 1'b1;
        cyc(4);
        rd(8'h08, 8'h00);
        rd(8'h02, 8'h00);
    endtask : t_mode
    initial begin
        cyc(6);
        rstn <= 1'b1;
        mode_select <= 1'b1;
        cyc(4);
        t_defaults();
        t_address();
        t_power();
        t_idle_rate();
        t_status();
        t_soft_reset();
        t_mode();
        wrap_up();
    end
    initial begin
        #1900000;
        mismatches++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
